// ---- verilog/serial_ctrl_defs.vh ----
// constants for the asynchronous serial control and rate block
// assumes a byte-wide register port with a 3-bit word address
`ifndef SERIAL_CTRL_DEFS_VH
`define SERIAL_CTRL_DEFS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_LINE_STATUS 3'h0
`define OFS_TX_RX_DATA 3'h1
`define OFS_BAUD_SEL 3'h2
`define OFS_FRAME_CFG 3'h3
`define OFS_INT_EN_CTRL 3'h4
`define OFS_RX_EXT_DIV 3'h5
`define OFS_TX_EXT_DIV 3'h7

// ----------------------------------------
// control register bits
// ----------------------------------------
`define BIT_TX_EMPTY_IE 7
`define BIT_TX_DONE_IE 6
`define BIT_RX_IE 5
`define BIT_IDLE_IE 4
`define BIT_TX_ON 3
`define BIT_RX_ON 2
`define BIT_RX_MUTE 1
`define BIT_SEND_BREAK 0

// ----------------------------------------
// frame configuration bits
// ----------------------------------------
`define BIT_RX_BIT8 7
`define BIT_TX_BIT8 6
`define BIT_WORD_LEN 4

// ----------------------------------------
// baud select fields
// ----------------------------------------
`define COARSE_HI 7
`define COARSE_LO 6
`define TXDIV_HI 5
`define TXDIV_LO 3
`define RXDIV_HI 2
`define RXDIV_LO 0

// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define RST_CTRL 8'h00
`define RST_BAUD 8'h00
`define RST_EXT 8'h00
`define RST_CFG 8'h00
`define COARSE_F0 4'h0
`define COARSE_F1 4'h2
`define COARSE_F2 4'h3
`define COARSE_F3 4'hC
`define OVERSAMPLE 16
`define FRAME_LEN_8 4'hA
`define FRAME_LEN_9 4'hB

`endif

// ---- verilog/serial_ctrl.v ----
// asynchronous serial transceiver: control, flags, data holding and rate generation
// assumes a single-cycle register port on mclk and asynchronous txd/rxd pins
//
// Summary of operation
// - tx empty enable passes the tx holding empty flag to the interrupt
// - tx done enable passes the transmission complete flag to the interrupt
// - rx enable passes overrun or rx holding full to the interrupt
// - idle enable passes the idle line flag to the interrupt
// - enabling the transmitter waits one bit time before first frame
// - toggling tx_on off and on mid-frame queues one preamble afterwards
// - tx pin is freed only when both enables clear or never enabled
// - setting rx_on starts hunting for a start bit; clearing stops reception
// - rx_mute selects mute mode; hardware clears it on wake-up
// - while send_break is set, break characters are sent
// - send_break set then cleared sends one break after current word
// - data writes fill tx holding, data reads return rx holding
// - coarse field divides bus clock by 1, 3, 4 or 13
// - tx divisor field divides by two to the code
// - rx divisor field divides by two to the code
// - nonzero rx extended divider further divides the rx rate
// - nonzero tx extended divider further divides the tx rate
// - bit rate is bus clock over 16 times the three factors
// - word length bit picks eight or nine data bits
// - tx empty sets on shifter load; clears by status access then write
// - rx flags clear by status access then data read
// - overrun when word done while rx holding full; holding kept
//
// Chosen here: the register addresses and the address-and-strobe port.

`include "serial_ctrl_defs.vh"

module serial_ctrl
(
    input wire mclk,
    input wire rst_n,
    input wire [2:0] addr,
    input wire [7:0] wdata,
    input wire wr_en,
    input wire rd_en,
    output reg [7:0] rdata,
    output wire irq,
    output reg txd,
    output wire txd_oe,
    input wire rxd
);

// ----------------------------------------
// registers
// ----------------------------------------
reg [7:0] ctrl_reg;
reg [7:0] baud_reg;
reg [7:0] cfg_reg;
reg [7:0] rx_ext_reg;
reg [7:0] tx_ext_reg;
reg [8:0] tx_holding_reg;
reg [8:0] rx_holding_reg;
reg tx_holding_empty_reg;
reg tx_done_flag_reg;
reg rx_holding_full_reg;
reg idle_reg;
reg overrun_reg;
reg noise_reg;
reg frame_err_reg;
reg status_seen_reg;

wire tx_on = ctrl_reg[`BIT_TX_ON];
wire rx_on = ctrl_reg[`BIT_RX_ON];
wire word9 = cfg_reg[`BIT_WORD_LEN];
wire [3:0] frame_len = word9 ? `FRAME_LEN_9 : `FRAME_LEN_8;
wire [7:0] status_val = {tx_holding_empty_reg, tx_done_flag_reg, rx_holding_full_reg,
    idle_reg, overrun_reg, noise_reg, frame_err_reg, 1'b0};

wire st_rd = rd_en && (addr == `OFS_LINE_STATUS);
wire dr_rd = rd_en && (addr == `OFS_TX_RX_DATA);
wire dr_wr = wr_en && (addr == `OFS_TX_RX_DATA);
wire tx_flag_clr = dr_wr && status_seen_reg;
wire rx_flag_clr = dr_rd && status_seen_reg;

// ----------------------------------------
// rate generation
// ----------------------------------------
reg [3:0] coarse_cnt_reg;
reg [3:0] coarse_max;
wire coarse_tick = (coarse_cnt_reg == coarse_max);

always @*
begin
    case (baud_reg[`COARSE_HI:`COARSE_LO])
        2'b00: coarse_max = `COARSE_F0;
        2'b01: coarse_max = `COARSE_F1;
        2'b10: coarse_max = `COARSE_F2;
        2'b11: coarse_max = `COARSE_F3;
        default: coarse_max = `COARSE_F0;
    endcase
end

always @(posedge mclk)
begin
    if (!rst_n || coarse_tick)
        coarse_cnt_reg <= 4'h0;
    else
        coarse_cnt_reg <= coarse_cnt_reg + 4'h1;
end

// index 0 is transmit, index 1 is receive; each gives a 16x oversample tick
wire [5:0] div_codes = {baud_reg[`RXDIV_HI:`RXDIV_LO], baud_reg[`TXDIV_HI:`TXDIV_LO]};
wire [15:0] ext_divs = {rx_ext_reg, tx_ext_reg};
wire [1:0] os_tick;

genvar g;
generate
    for (g = 0; g < 2; g = g + 1)
    begin : rate_chan
        reg [6:0] conv_cnt_reg;
        reg [7:0] ext_cnt_reg;
        wire [2:0] code = div_codes[3*g+2:3*g];
        wire [7:0] ext = ext_divs[8*g+7:8*g];
        wire [6:0] conv_max = (7'h01 << code) - 7'h01;
        wire conv_tick = coarse_tick && (conv_cnt_reg == conv_max);
        wire ext_last = (ext == 8'h00) || (ext_cnt_reg == ext - 8'h01);
        assign os_tick[g] = conv_tick && ext_last;

        always @(posedge mclk)
        begin
            if (!rst_n)
            begin
                conv_cnt_reg <= 7'h00;
                ext_cnt_reg <= 8'h00;
            end
            else
            begin
                if (conv_tick)
                    conv_cnt_reg <= 7'h00;
                else if (coarse_tick)
                    conv_cnt_reg <= conv_cnt_reg + 7'h01;
                if (os_tick[g] || (ext == 8'h00))
                    ext_cnt_reg <= 8'h00;
                else if (conv_tick)
                    ext_cnt_reg <= ext_cnt_reg + 8'h01;
            end
        end
    end
endgenerate

wire tx_tick = os_tick[0];
wire rx_tick = os_tick[1];

// ----------------------------------------
// transmitter
// ----------------------------------------
localparam TX_IDLE = 1'b0;
localparam TX_SHIFT = 1'b1;

reg tx_state_reg;
reg [10:0] tx_shift_reg;
reg [3:0] tx_left_reg;
reg [3:0] tx_sub_reg;
reg tx_is_data_reg;
reg tx_on_prev_reg;
reg brk_prev_reg;
reg tx_delay_reg;
reg pend_pre_reg;
reg pend_brk_reg;
reg tx_used_reg;

wire tx_busy = (tx_state_reg == TX_SHIFT);
wire tx_rise = tx_on && !tx_on_prev_reg;
wire brk_fall = brk_prev_reg && !ctrl_reg[`BIT_SEND_BREAK];
wire bit_end = tx_tick && (tx_sub_reg == 4'hF);
wire frame_end = tx_busy && bit_end && (tx_left_reg == 4'h1);
// start on a tick so the start bit is whole
wire tx_load_data = !tx_busy && tx_on && tx_tick && !tx_delay_reg && !pend_pre_reg
    && !pend_brk_reg && !ctrl_reg[`BIT_SEND_BREAK] && !tx_holding_empty_reg;

// pin released when both enables off or never enabled
assign txd_oe = tx_on || (tx_used_reg && rx_on);

always @(posedge mclk)
begin
    if (!rst_n)
    begin
        tx_state_reg <= TX_IDLE;
        tx_shift_reg <= 11'h7FF;
        tx_left_reg <= 4'h0;
        tx_sub_reg <= 4'h0;
        tx_is_data_reg <= 1'b0;
        tx_on_prev_reg <= 1'b0;
        brk_prev_reg <= 1'b0;
        tx_delay_reg <= 1'b0;
        pend_pre_reg <= 1'b0;
        pend_brk_reg <= 1'b0;
        tx_used_reg <= 1'b0;
        txd <= 1'b1;
    end
    else
    begin
        tx_on_prev_reg <= tx_on;
        brk_prev_reg <= ctrl_reg[`BIT_SEND_BREAK];
        if (tx_on)
            tx_used_reg <= 1'b1;
        if (tx_rise && !tx_busy)
            tx_delay_reg <= 1'b1;
        // off-on pulse during a frame queues a preamble
        if (tx_rise && tx_busy)
            pend_pre_reg <= 1'b1;
        // falling send_break queues one break word
        if (brk_fall)
            pend_brk_reg <= 1'b1;
        if (tx_busy)
        begin
            if (tx_tick)
                tx_sub_reg <= tx_sub_reg + 4'h1;
            if (bit_end)
            begin
                tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
                tx_left_reg <= tx_left_reg - 4'h1;
                txd <= tx_shift_reg[1];
                if (tx_left_reg == 4'h1)
                begin
                    tx_state_reg <= TX_IDLE;
                    txd <= 1'b1;
                end
            end
        end
        else if (tx_on && tx_tick)
        begin
            tx_sub_reg <= 4'h0;
            if (tx_delay_reg)
            begin
                tx_delay_reg <= 1'b0;
                tx_shift_reg <= 11'h7FF;
                tx_left_reg <= 4'h1;
                tx_is_data_reg <= 1'b0;
                tx_state_reg <= TX_SHIFT;
            end
            else if (pend_pre_reg)
            begin
                pend_pre_reg <= 1'b0;
                tx_shift_reg <= 11'h7FF;
                tx_left_reg <= frame_len;
                tx_is_data_reg <= 1'b0;
                tx_state_reg <= TX_SHIFT;
            end
            else if (pend_brk_reg || ctrl_reg[`BIT_SEND_BREAK])
            begin
                pend_brk_reg <= 1'b0;
                tx_shift_reg <= 11'h000;
                txd <= 1'b0;
                tx_left_reg <= frame_len;
                tx_is_data_reg <= 1'b0;
                tx_state_reg <= TX_SHIFT;
            end
            else if (tx_load_data)
            begin
                // frame of eight or nine data bits
                tx_shift_reg <= word9 ? {1'b1, tx_holding_reg, 1'b0}
                    : {2'b11, tx_holding_reg[7:0], 1'b0};
                txd <= 1'b0;
                tx_left_reg <= frame_len;
                tx_is_data_reg <= 1'b1;
                tx_state_reg <= TX_SHIFT;
            end
        end
    end
end

// ----------------------------------------
// receiver
// ----------------------------------------
localparam RX_HUNT = 1'b0;
localparam RX_BITS = 1'b1;

reg rxd_meta_reg;
reg rxd_sync_reg;
reg rx_state_reg;
reg [3:0] rx_sub_reg;
reg [3:0] rx_idx_reg;
reg [8:0] rx_shift_reg;
reg [2:0] rx_samp_reg;
reg rx_noise_reg;
reg [7:0] idle_cnt_reg;
reg idle_armed_reg;

wire rx_vote = (rx_samp_reg[0] & rx_samp_reg[1]) | (rx_samp_reg[1] & rx_samp_reg[2])
    | (rx_samp_reg[0] & rx_samp_reg[2]);
wire rx_disagree = (rx_samp_reg != 3'b000) && (rx_samp_reg != 3'b111);
wire rx_decide = rx_tick && (rx_state_reg == RX_BITS) && (rx_sub_reg == 4'hA);
wire rx_last = (rx_idx_reg == frame_len - 4'h1);
wire rx_done = rx_decide && rx_last;
wire rx_false_start = rx_decide && (rx_idx_reg == 4'h0) && rx_vote;
wire rx_mute_on = ctrl_reg[`BIT_RX_MUTE];
wire [8:0] rx_word = word9 ? rx_shift_reg : {1'b0, rx_shift_reg[8:1]};
wire idle_seen = rx_tick && (idle_cnt_reg == {frame_len, 4'hF});
wire rx_wake = idle_seen && rx_mute_on;
wire rx_overrun = rx_done && !rx_mute_on && rx_holding_full_reg;
wire rx_store = rx_done && !rx_mute_on && !rx_holding_full_reg;

always @(posedge mclk)
begin
    if (!rst_n)
    begin
        rxd_meta_reg <= 1'b1;
        rxd_sync_reg <= 1'b1;
        rx_state_reg <= RX_HUNT;
        rx_sub_reg <= 4'h0;
        rx_idx_reg <= 4'h0;
        rx_shift_reg <= 9'h000;
        rx_samp_reg <= 3'b111;
        rx_noise_reg <= 1'b0;
        idle_cnt_reg <= 8'h00;
    end
    else
    begin
        rxd_meta_reg <= rxd;
        rxd_sync_reg <= rxd_meta_reg;
        if (!rx_on)
        begin
            rx_state_reg <= RX_HUNT;
            idle_cnt_reg <= 8'h00;
        end
        else if (rx_state_reg == RX_HUNT)
        begin
            rx_sub_reg <= 4'h0;
            rx_idx_reg <= 4'h0;
            rx_noise_reg <= 1'b0;
            if (!rxd_sync_reg)
            begin
                rx_state_reg <= RX_BITS;
                idle_cnt_reg <= 8'h00;
            end
            else if (rx_tick && !idle_seen)
                idle_cnt_reg <= idle_cnt_reg + 8'h01;
        end
        else if (rx_tick)
        begin
            rx_sub_reg <= rx_sub_reg + 4'h1;
            // majority of three mid-bit samples; disagreement marks noise
            if (rx_sub_reg >= 4'h7 && rx_sub_reg <= 4'h9)
                rx_samp_reg <= {rx_samp_reg[1:0], rxd_sync_reg};
            if (rx_decide)
            begin
                if (rx_disagree)
                    rx_noise_reg <= 1'b1;
                if (rx_idx_reg != 4'h0 && !rx_last)
                    rx_shift_reg <= {rx_vote, rx_shift_reg[8:1]};
                if (rx_false_start || rx_last)
                    rx_state_reg <= RX_HUNT;
            end
            if (rx_sub_reg == 4'hF)
                rx_idx_reg <= rx_idx_reg + 4'h1;
        end
    end
end

// ----------------------------------------
// register writes and flags
// ----------------------------------------
always @(posedge mclk)
begin
    if (!rst_n)
    begin
        ctrl_reg <= `RST_CTRL;
        baud_reg <= `RST_BAUD;
        cfg_reg <= `RST_CFG;
        rx_ext_reg <= `RST_EXT;
        tx_ext_reg <= `RST_EXT;
        tx_holding_reg <= 9'h000;
        rx_holding_reg <= 9'h000;
        tx_holding_empty_reg <= 1'b1;
        tx_done_flag_reg <= 1'b1;
        rx_holding_full_reg <= 1'b0;
        idle_reg <= 1'b0;
        overrun_reg <= 1'b0;
        noise_reg <= 1'b0;
        frame_err_reg <= 1'b0;
        status_seen_reg <= 1'b0;
        idle_armed_reg <= 1'b0;
    end
    else
    begin
        if (st_rd)
            status_seen_reg <= 1'b1;
        else if (dr_rd || dr_wr)
            status_seen_reg <= 1'b0;
        if (wr_en)
        begin
            case (addr)
                `OFS_INT_EN_CTRL: ctrl_reg <= wdata;
                `OFS_BAUD_SEL: baud_reg <= wdata;
                `OFS_FRAME_CFG: cfg_reg <= {cfg_reg[7], wdata[6:0]};
                `OFS_RX_EXT_DIV: rx_ext_reg <= wdata;
                `OFS_TX_EXT_DIV: tx_ext_reg <= wdata;
                // write side of the data address
                `OFS_TX_RX_DATA: tx_holding_reg <= {cfg_reg[`BIT_TX_BIT8], wdata};
                default: ;
            endcase
        end
        if (rx_wake)
            ctrl_reg[`BIT_RX_MUTE] <= 1'b0;
        // clear by sequence; a same-cycle load wins
        if (tx_load_data)
            tx_holding_empty_reg <= 1'b1;
        else if (tx_flag_clr)
            tx_holding_empty_reg <= 1'b0;
        if (frame_end && tx_is_data_reg && tx_holding_empty_reg)
            tx_done_flag_reg <= 1'b1;
        else if (tx_flag_clr)
            tx_done_flag_reg <= 1'b0;
        // receive flags clear by sequence; new events win
        if (rx_store)
        begin
            rx_holding_reg <= rx_word;
            cfg_reg[`BIT_RX_BIT8] <= rx_word[8];
            rx_holding_full_reg <= 1'b1;
            noise_reg <= rx_noise_reg || rx_disagree;
            frame_err_reg <= !rx_vote;
            idle_armed_reg <= 1'b1;
        end
        else if (rx_flag_clr)
        begin
            rx_holding_full_reg <= 1'b0;
            noise_reg <= 1'b0;
            frame_err_reg <= 1'b0;
        end
        if (rx_overrun)
            overrun_reg <= 1'b1;
        else if (rx_flag_clr)
            overrun_reg <= 1'b0;
        // idle flag only after a received word re-arms it
        if (idle_seen && idle_armed_reg && !rx_mute_on)
        begin
            idle_reg <= 1'b1;
            idle_armed_reg <= rx_store;
        end
        else if (rx_flag_clr)
            idle_reg <= 1'b0;
    end
end

// ----------------------------------------
// read data
// ----------------------------------------
always @(posedge mclk)
begin
    if (!rst_n)
        rdata <= 8'h00;
    else if (rd_en)
    begin
        case (addr)
            `OFS_LINE_STATUS: rdata <= status_val;
            // read side of the data address
            `OFS_TX_RX_DATA: rdata <= rx_holding_reg[7:0];
            `OFS_BAUD_SEL: rdata <= baud_reg;
            `OFS_FRAME_CFG: rdata <= cfg_reg;
            `OFS_INT_EN_CTRL: rdata <= ctrl_reg;
            `OFS_RX_EXT_DIV: rdata <= rx_ext_reg;
            `OFS_TX_EXT_DIV: rdata <= tx_ext_reg;
            default: rdata <= 8'h00;
        endcase
    end
    else
        rdata <= 8'h00;
end

// ----------------------------------------
// interrupt
// ----------------------------------------
// gated sources into one request
assign irq = (ctrl_reg[`BIT_TX_EMPTY_IE] && tx_holding_empty_reg)
    || (ctrl_reg[`BIT_TX_DONE_IE] && tx_done_flag_reg)
    || (ctrl_reg[`BIT_RX_IE] && (overrun_reg || rx_holding_full_reg))
    || (ctrl_reg[`BIT_IDLE_IE] && idle_reg);

endmodule // serial_ctrl

// ---- dv/serial_ctrl_props.sv ----
// concurrent checks on the serial control block pins
// assumes a bind to serial_ctrl and register strobes that never overlap
`include "serial_ctrl_defs.vh"

module serial_ctrl_props
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rdata,
    input wire logic irq,
    input wire logic txd,
    input wire logic txd_oe,
    input wire logic rxd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ctrl_sh, baud_sh, rxe_sh, txe_sh, exp_rd;
    logic ever_tx;
    int low_cnt, pr, bit_len;

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // ----------------------------------------
    // shadow registers and run counter
    // ----------------------------------------
    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            ctrl_sh <= 8'h00;
            baud_sh <= 8'h00;
            rxe_sh <= 8'h00;
            txe_sh <= 8'h00;
            ever_tx <= 1'b0;
            low_cnt <= 0;
        end
        else
        begin
            if (wr_en && addr == `OFS_INT_EN_CTRL)
                ctrl_sh <= wdata;
            if (wr_en && addr == `OFS_BAUD_SEL)
                baud_sh <= wdata;
            if (wr_en && addr == `OFS_RX_EXT_DIV)
                rxe_sh <= wdata;
            if (wr_en && addr == `OFS_TX_EXT_DIV)
                txe_sh <= wdata;
            ever_tx <= ever_tx | ctrl_sh[3];
            low_cnt <= txd ? 0 : low_cnt + 1;
        end
    end

    // mute bit excluded from readback: hardware may clear it
    always @*
    begin
        case (addr)
            `OFS_BAUD_SEL: exp_rd = baud_sh;
            `OFS_INT_EN_CTRL: exp_rd = ctrl_sh;
            `OFS_RX_EXT_DIV: exp_rd = rxe_sh;
            default: exp_rd = txe_sh;
        endcase
        case (baud_sh[7:6])
            2'h0: pr = 1;
            2'h1: pr = 3;
            2'h2: pr = 4;
            default: pr = 13;
        endcase
        bit_len = 16 * pr * (1 << baud_sh[5:3]) * ((txe_sh == 8'h00) ? 1 : int'(txe_sh));
    end

    a_reset_quiet: assert property (
        !$past(rst_n) |-> !irq && txd && !txd_oe) else $error("pins not quiet after reset");
    a_irq_from_flags: assert property (
        rd_en && addr == `OFS_LINE_STATUS |=> $past(irq) ==
        ((|(rdata[7:4] & $past(ctrl_sh[7:4]))) || (rdata[3] && $past(ctrl_sh[5]))))
        else $error("irq disagrees with flags and enables");
    a_reg_readback: assert property (
        rd_en && addr inside {3'h2, 3'h4, 3'h5, 3'h7} |=> ((rdata ^ $past(exp_rd)) &
        (($past(addr) == `OFS_INT_EN_CTRL) ? 8'hFD : 8'hFF)) == 8'h00)
        else $error("register readback mismatch");
    a_mute_no_set: assert property (
        rd_en && addr == `OFS_INT_EN_CTRL && !ctrl_sh[1] |=> !rdata[1])
        else $error("mute set without software");
    a_pin_held: assert property (
        ctrl_sh[3] || (ever_tx && ctrl_sh[2]) |-> txd_oe) else $error("tx pin released early");
    a_bit_width: assert property (
        $rose(txd) |-> (low_cnt % bit_len) == 0) else $error("low run not whole bits");
    a_start_delay: assert property (
        $rose(ctrl_sh[3]) |-> txd [*8]) else $error("frame began without idle bit");
    a_break_sent: assert property (
        $rose(ctrl_sh[0]) && ctrl_sh[3] && bit_len == 16 |-> ##[1:400] !txd)
        else $error("break word not sent");

    c_frame_end: cover property ($rose(txd) && low_cnt == 160);
    c_irq_up: cover property ($rose(irq));
    c_unmapped: cover property (rd_en && addr == 3'h6);
endmodule // serial_ctrl_props

// ---- dv/remote_serial.sv ----
// behavioural far-end transceiver on the serial pins
// assumes the bench sets tx_bits before each word it expects on txd
module remote_serial
(
    input wire logic mclk,
    input wire logic txd,
    output logic rxd
);
    timeunit 1ns;
    timeprecision 1ps;
    int tx_bits = 16;
    int n_got = 0;
    logic [7:0] got = 8'h00;
    logic got_stop = 1'b1;

    // line idles at mark level between words
    initial
    begin
        rxd = 1'b1;
    end

    task automatic send(input logic [7:0] w, input int bits);
        logic [9:0] f;
        begin
            f = {1'b1, w, 1'b0};
            for (int i = 0; i < 10; i++)
            begin
                rxd <= f[i];
                repeat (bits) @(posedge mclk);
            end
        end
    endtask

    // mid-bit sampling, lsb first, stop kept to spot a break
    always
    begin
        @(negedge txd);
        repeat (tx_bits / 2) @(posedge mclk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (tx_bits) @(posedge mclk);
            got[i] = txd;
        end
        repeat (tx_bits) @(posedge mclk);
        got_stop = txd;
        n_got++;
    end
endmodule // remote_serial

// ---- dv/async_serial_ctrl_baud_test.sv ----
// self-checking bench for the serial control and rate block
// assumes the remote model on the pins and the checker bound below
`include "serial_ctrl_defs.vh"

module async_serial_ctrl_baud_test;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [7:0] baud;
        logic [7:0] rxe;
        logic [7:0] txe;
        int txb;
        int rxb;
        logic [7:0] d;
    } row_t;
    // bit length in cycles: 16 x coarse x divisor x extended factor
    row_t rows[6] = '{
        '{8'h00, 8'h00, 8'h00, 16, 16, 8'hA5},
        '{8'h48, 8'h00, 8'h00, 96, 48, 8'h3C},
        '{8'h80, 8'h00, 8'h00, 64, 64, 8'h81},
        '{8'hC0, 8'h00, 8'h02, 416, 208, 8'h5E},
        '{8'h19, 8'h03, 8'h00, 128, 96, 8'hC3},
        '{8'h00, 8'h80, 8'h01, 16, 2048, 8'h0F}
    };
    logic [2:0] ra[4] = '{`OFS_BAUD_SEL, `OFS_INT_EN_CTRL, `OFS_RX_EXT_DIV, `OFS_TX_EXT_DIV};
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    wire [7:0] rdata;
    wire irq, txd, txd_oe, rxd;
    logic [7:0] rv;
    int n_errors = 0;
    int comparisons = 0;
    int n0;

    serial_ctrl serial_ctrl_i (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq), .txd(txd), .txd_oe(txd_oe),
        .rxd(rxd));
    remote_serial remote_serial_i (.mclk(mclk), .txd(txd), .rxd(rxd));

    initial
    begin
        forever #5 mclk = ~mclk;
    end

    // ----------------------------------------
    // bus and check tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        begin
            comparisons++;
            if (seen !== exp)
            begin
                n_errors++;
                $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        begin
            @(posedge mclk);
            addr <= a;
            wdata <= d;
            wr_en <= 1'b1;
            @(posedge mclk);
            wr_en <= 1'b0;
        end
    endtask

    task automatic rd(input logic [2:0] a);
        begin
            @(posedge mclk);
            addr <= a;
            rd_en <= 1'b1;
            @(posedge mclk);
            rd_en <= 1'b0;
            #1;
            rv = rdata;
        end
    endtask

    task automatic wrrd(input logic [2:0] a, input logic [7:0] d);
        begin
            wr(a, d);
            rd(a);
            chk("readback", rv, d);
        end
    endtask

    // bounded wait for the remote end to finish a word, then the stop bit
    task automatic await_word(input int first, input int bits);
        begin
            for (int k = 0; k < 8000 && remote_serial_i.n_got == first; k++)
                @(posedge mclk);
            repeat (bits) @(posedge mclk);
        end
    endtask

    task automatic tx_word(input logic [7:0] d, input int bits);
        int first;
        begin
            rd(`OFS_LINE_STATUS);
            chk("tx flags", {6'h00, rv[7:6]}, 8'h03);
            first = remote_serial_i.n_got;
            wr(`OFS_TX_RX_DATA, d);
            await_word(first, bits);
        end
    endtask

    task wrap_up;
        begin
            $display("comparisons %0d errors %0d", comparisons, n_errors);
            if (n_errors == 0 && comparisons > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        chk("idle pins", {5'h00, irq, txd, txd_oe}, 8'h02);
        rd(`OFS_LINE_STATUS);
        chk("status reset", rv, 8'hC0);
        foreach (ra[i])
        begin
            rd(ra[i]);
            chk("reg reset", rv, 8'h00);
        end
        wr(3'h6, 8'hFF);
        rd(3'h6);
        chk("unmapped", rv, 8'h00);
        for (int b = 4; b < 8; b++)
        begin
            wr(`OFS_INT_EN_CTRL, 8'h01 << b);
            #1;
            chk("irq gate", {7'h00, irq}, {7'h00, b > 5});
        end
        wr(`OFS_INT_EN_CTRL, 8'h2C);
        foreach (rows[i])
        begin
            wrrd(`OFS_BAUD_SEL, rows[i].baud);
            wrrd(`OFS_RX_EXT_DIV, rows[i].rxe);
            wrrd(`OFS_TX_EXT_DIV, rows[i].txe);
            remote_serial_i.tx_bits = rows[i].txb;
            tx_word(rows[i].d, rows[i].txb);
            chk("tx word", remote_serial_i.got, rows[i].d);
            remote_serial_i.send(~rows[i].d, rows[i].rxb);
            #1;
            chk("rx irq", {7'h00, irq}, 8'h01);
            rd(`OFS_LINE_STATUS);
            rd(`OFS_TX_RX_DATA);
            chk("rx word", rv, ~rows[i].d);
            rd(`OFS_LINE_STATUS);
            chk("rx full clear", {7'h00, rv[5]}, 8'h00);
        end
        // two words with no read in between
        wrrd(`OFS_RX_EXT_DIV, 8'h00);
        remote_serial_i.send(8'h11, 16);
        remote_serial_i.send(8'h22, 16);
        rd(`OFS_LINE_STATUS);
        chk("overrun", {7'h00, rv[3]}, 8'h01);
        rd(`OFS_TX_RX_DATA);
        chk("held word", rv, 8'h11);
        wr(`OFS_FRAME_CFG, 8'h50);
        remote_serial_i.send(8'h96, 16);
        repeat (20) @(posedge mclk);
        rd(`OFS_FRAME_CFG);
        chk("ninth bit", rv, 8'hD0);
        wr(`OFS_FRAME_CFG, 8'h00);
        // mute only after a word has been taken in
        remote_serial_i.send(8'h77, 16);
        wr(`OFS_INT_EN_CTRL, 8'h1E);
        repeat (400) @(posedge mclk);
        rd(`OFS_INT_EN_CTRL);
        chk("wake clears mute", rv, 8'h1C);
        chk("idle irq", {7'h00, irq}, 8'h01);
        remote_serial_i.tx_bits = 16;
        n0 = remote_serial_i.n_got;
        wr(`OFS_INT_EN_CTRL, 8'h0D);
        wr(`OFS_INT_EN_CTRL, 8'h0C);
        await_word(n0, 16);
        chk("break word", remote_serial_i.got | {7'h00, remote_serial_i.got_stop}, 8'h00);
        wr(`OFS_INT_EN_CTRL, 8'h04);
        repeat (200) @(posedge mclk);
        chk("pin kept", {7'h00, txd_oe}, 8'h01);
        wr(`OFS_INT_EN_CTRL, 8'h00);
        repeat (200) @(posedge mclk);
        chk("pin freed", {7'h00, txd_oe}, 8'h00);
        wrap_up;
    end

    // run needs about 40k cycles; cut a hang at 100k
    initial
    begin
        #1_000_000;
        n_errors++;
        wrap_up;
    end
endmodule // async_serial_ctrl_baud_test

bind serial_ctrl serial_ctrl_props serial_ctrl_props_i (.mclk, .rst_n, .addr, .wdata,
    .wr_en, .rd_en, .rdata, .irq, .txd, .txd_oe, .rxd);
